//--- dv/dram_refresh_interval_timer_tb.sv
// self-checking bench for the refresh interval timer
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dram_refresh_interval_timer_tb;
    logic                        mclk = 1'b0;  // system clock
    logic                        nrst = 1'b0;  // power-on reset
    refresh_timer_pkg::bus_req_t bus_req = '0; // register bus request
    logic [15:0]                 bus_rdata;
    logic                        match_irq_request, cas_first_refresh, self_refresh_mode;
    logic [1:0]                  refresh_wait_sel;
    int                          n_mismatch = 0, samples_checked = 0;
    logic [7:0]                  seed = 8'h50; // fixed start keeps runs repeatable
    logic [2:0]                  regs [4] = '{3'h0, 3'h2, 3'h4, 3'h6};
    logic [7:0]                  pws [4] = '{8'hA5, 8'h69, 8'h96, 8'h5A};
    logic [15:0]                 q, q0;
    logic [7:0]                  r, c;
    int                          n, ex;
    always #5 mclk = ~mclk;
    dram_refresh_interval_timer dut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .match_irq_request(match_irq_request), .cas_first_refresh(cas_first_refresh),
        .self_refresh_mode(self_refresh_mode), .refresh_wait_sel(refresh_wait_sel));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // expected tick spacing per select code
    function automatic int div_of(input int s);
        return (s == 7) ? 4096 : (1 << (2 * s - 1));
    endfunction : div_of
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic w);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, word: w};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic w, output logic [15:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, word: w};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd
    // bounded wait for the next refresh pulse; n is edges waited
    task automatic wait_cas(output int k);
        k = 0;
        do begin @(posedge mclk); #1; k++; end while (cas_first_refresh !== 1'b1 && k < 9000);
        if (k >= 9000) begin n_mismatch++; conclude(); end
    endtask : wait_cas
    task automatic quiet();
        repeat (30) begin @(posedge mclk); #1; `CHK(cas_first_refresh, 1'b0) end
    endtask : quiet
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(regs[i], 1'b1, q);
            `CHK(q, (i == 2) ? 16'h00FF : 16'h0000)
        end
        rd(3'h5, 1'b0, q); `CHK(q, 16'h00FF)
        rd(3'h4, 1'b0, q); `CHK(q, 16'h0000)
        // wrong password and byte writes leave every register alone
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed); r = seed; seed = lfsr(seed);
            rd(regs[i % 4], 1'b1, q0);
            wr(regs[i % 4], {(seed == pws[i % 4]) ? ~seed : seed, r}, 1'b1);
            wr(regs[i % 4], {pws[i % 4], r}, 1'b0);
            rd(regs[i % 4], 1'b1, q); `CHK(q, q0)
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(3'h4, {8'h96, seed}, 1'b1); rd(3'h4, 1'b1, q); `CHK(q, {8'h00, seed})
            wr(3'h2, {8'h69, ~seed}, 1'b1); rd(3'h2, 1'b1, q); `CHK(q, {8'h00, ~seed})
        end
        wr(3'h0, 16'hA5FF, 1'b1); rd(3'h0, 1'b1, q); `CHK(q, 16'h0078)
        wr(3'h0, 16'hA500, 1'b1);
        // tick spacing for every nonzero select code; interval is divisor times constant plus one
        wr(3'h6, 16'h5A80, 1'b1);
        for (int s = 1; s < 8; s++) begin
            seed = lfsr(seed); c = (s == 1) ? (seed & 8'h0F) : 8'h00;
            wr(3'h4, {8'h96, c}, 1'b1);
            wr(3'h0, {8'hA5, 2'b01, s[2:0], 3'h0}, 1'b1);
            wr(3'h2, 16'h6900, 1'b1);
            wait_cas(n); wait_cas(n); ex = div_of(s) * (c + 1);
            `CHK(n, ex)
        end
        // flag survives an unarmed zero write; enable masks the request
        wr(3'h0, 16'hA540, 1'b1); #1 `CHK(match_irq_request, 1'b1)
        wr(3'h0, 16'hA500, 1'b1); #1 `CHK(match_irq_request, 1'b0)
        rd(3'h0, 1'b1, q); `CHK(q, 16'h0080)
        wr(3'h0, 16'hA500, 1'b1); rd(3'h0, 1'b1, q); `CHK(q, 16'h0000)
        // refresh disabled, then self mode: timer runs but no requests
        wr(3'h6, 16'h5A70, 1'b1); #1 `CHK(refresh_wait_sel, 2'h3)
        wr(3'h4, 16'h9600, 1'b1); wr(3'h0, 16'hA508, 1'b1);
        quiet();
        rd(3'h0, 1'b1, q); `CHK(q[7], 1'b1)
        wr(3'h6, 16'h5AC0, 1'b1); #1 `CHK(self_refresh_mode, 1'b1)
        quiet();
        wr(3'h6, 16'h5A80, 1'b1); wait_cas(n); wait_cas(n); `CHK(n, 2)
        conclude();
    end
endmodule : dram_refresh_interval_timer_tb

//--- dv/refresh_timer_checker.sv
// port-level assertions for the refresh interval timer
`timescale 1ns/1ps
module refresh_timer_checker (
    input wire logic                        mclk,
    input wire logic                        nrst,
    input wire refresh_timer_pkg::bus_req_t bus_req,
    input wire logic [15:0]                 bus_rdata,
    input wire logic                        match_irq_request,
    input wire logic                        cas_first_refresh,
    input wire logic                        self_refresh_mode,
    input wire logic [1:0]                  refresh_wait_sel
);
    // ----------------------------------------------------------------
    // access decode helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic ww   = bus_req.wr && bus_req.word;  // word write
    wire logic rctl = bus_req.addr[2:1] == refresh_timer_pkg::ADDR_REFRESH_CTL[2:1];
    wire logic rpw  = bus_req.wdata[15:8] == refresh_timer_pkg::PW_REFRESH_CTL;
    wire logic rst_rd = bus_req.rd && bus_req.word && bus_req.addr[2:1] == 2'h0;  // status read
    wire logic cst  = bus_req.addr[2:1] == refresh_timer_pkg::ADDR_CONSTANT[2:1];
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    upper_zero_a: assert property (bus_rdata[15:8] == 8'h00)
        else $error("upper read byte not zero");
    reserved_zero_a: assert property ($past(rst_rd) |-> bus_rdata[2:0] == 3'h0)
        else $error("reserved status bits not zero");
    const_write_a: assert property ((ww && cst && bus_req.wdata[15:8] == 8'h96)
        ##1 !bus_req.wr ##1 (bus_req.rd && bus_req.word && cst)
        |=> bus_rdata[7:0] == $past(bus_req.wdata[7:0], 3)) else $error("constant readback wrong");
    irq_read_a: assert property ($past(rst_rd) |-> (bus_rdata[7] & bus_rdata[6]) == $past(match_irq_request))
        else $error("interrupt request disagrees with flag and enable");
    refresh_pulse_a: assert property (cas_first_refresh |=> !cas_first_refresh)
        else $error("refresh request longer than one cycle");
    self_quiet_a: assert property (self_refresh_mode && $past(self_refresh_mode) |-> !cas_first_refresh)
        else $error("refresh request in self mode");
    byte_guard_a: assert property (bus_req.wr && !bus_req.word |=> $stable(refresh_wait_sel) && $stable(self_refresh_mode))
        else $error("byte write changed refresh control");
    bad_pw_a: assert property (ww && rctl && !rpw |=> $stable(refresh_wait_sel) && $stable(self_refresh_mode))
        else $error("wrong password changed refresh control");
    rctl_write_a: assert property (ww && rctl && rpw |=> refresh_wait_sel == $past(bus_req.wdata[5:4]))
        else $error("refresh wait field not loaded");
    // main scenarios reached
    refresh_seen_c: cover property (cas_first_refresh);
    irq_seen_c: cover property ($rose(match_irq_request));
    self_seen_c: cover property (self_refresh_mode);
endmodule : refresh_timer_checker

bind dram_refresh_interval_timer refresh_timer_checker u_chk (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .match_irq_request(match_irq_request), .cas_first_refresh(cas_first_refresh),
    .self_refresh_mode(self_refresh_mode), .refresh_wait_sel(refresh_wait_sel));

//--- hw/dram_refresh_interval_timer.sv
// refresh interval timer: password-protected registers, counter, compare and request outputs
//
// What this block does
// - control/status written by word with its password
// - counter written by word with its password
// - constant written by word with its password
// - wrong password discards the write
// - byte writes never change protected registers
// - byte and word reads; upper byte zero
// - status and counter zero on power-on only
// - constant all ones on power-on only
// - three-bit select picks one of seven taps
// - counting starts once a nonzero select is written
// - eight-bit up-counter, upper byte reads zero
// - compare continuously; equality sets the flag
// - match clears counter; period is constant plus one
// - refresh enabled, self mode off: each match requests a refresh
// - refresh disabled: no requests, plain interval timer
// - interrupt request is flag and enable
// - flag clears only by read-one then write-zero
// - constant upper byte unwritable and reads zero
// - reserved status bits read zero
// - flag bit7, enable bit6, select bits5..3
//
// counter steps only on prescaler ticks; a software load sets it in any cycle
// a refused write is dropped silently
// nrst is the only reset of this state
`timescale 1ns/1ps
module dram_refresh_interval_timer (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // register bus, one request per cycle
    input  wire refresh_timer_pkg::bus_req_t bus_req,
    output logic [15:0]                      bus_rdata,
    // event and level outputs
    output logic                             match_irq_request,
    output logic                             cas_first_refresh,
    // refresh control levels
    output logic                             self_refresh_mode,
    output logic [1:0]                       refresh_wait_sel
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // control/status fields
    logic                             match_flag_reg;        // sticky compare flag
    logic                             match_flag_next;
    logic                             match_irq_enable_reg;  // interrupt enable
    logic                             match_irq_enable_next;
    // prescaler tap
    refresh_timer_pkg::prescale_sel_t prescale_select_reg;   // tick source
    refresh_timer_pkg::prescale_sel_t prescale_select_next;

    // counter and match value
    logic [7:0]                       count_reg;             // interval counter
    logic [7:0]                       count_next;
    logic [7:0]                       constant_reg;          // match value
    logic [7:0]                       constant_next;

    // refresh control bits
    logic [3:0]                       refresh_ctl_reg;       // refresh control bits 7..4
    logic [3:0]                       refresh_ctl_next;

    // clear handshake
    logic                             clear_armed_reg;       // flag was read as one
    logic                             clear_armed_next;

    // bus read data
    logic [15:0]                      rdata_reg;             // read data, one cycle late
    logic [15:0]                      rdata_next;

    // refresh request
    logic                             refresh_req_reg;       // refresh request pulse
    logic                             refresh_req_next;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // tick and compare
    logic        tick;          // selected prescaler tick
    logic        equal;         // counter equals constant
    logic        match_event;   // tick while equal

    // write accept strobes
    logic        wr_status;     // accepted word write, per register
    logic        wr_count;
    logic        wr_constant;
    logic        wr_refresh;

    // shared data paths
    logic [7:0]  wlow;          // data byte of a write
    logic [15:0] reg_word;      // selected register as a word

    // accepted protected write: word size, matching address and password
    // addr[0] is ignored: a word covers both bytes
    // a byte write never passes, whatever its data
    function automatic logic pw_write(
        input refresh_timer_pkg::bus_req_t r,
        input logic [2:0]                  a,
        input logic [7:0]                  pw);
        pw_write = r.wr && r.word && (r.addr[2:1] == a[2:1]) && (r.wdata[15:8] == pw);
    endfunction : pw_write

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // free divider; a select change takes
    // effect on the next tap boundary
    refresh_prescaler u_prescaler (
        .mclk (mclk),
        .nrst (nrst),
        .sel  (prescale_select_reg),
        .tick (tick)
    );

    // ----------------------------------------------------------------
    // write decode and compare
    // ----------------------------------------------------------------
    // one decode per register; at most one is
    // true since the strobes are exclusive
    always_comb begin
        wlow        = bus_req.wdata[7:0];

        wr_status   = pw_write(bus_req, refresh_timer_pkg::ADDR_CTRL_STATUS,
                               refresh_timer_pkg::PW_CTRL_STATUS);
        wr_count    = pw_write(bus_req, refresh_timer_pkg::ADDR_COUNT,
                               refresh_timer_pkg::PW_COUNT);
        wr_constant = pw_write(bus_req, refresh_timer_pkg::ADDR_CONSTANT,
                               refresh_timer_pkg::PW_CONSTANT);
        wr_refresh  = pw_write(bus_req, refresh_timer_pkg::ADDR_REFRESH_CTL,
                               refresh_timer_pkg::PW_REFRESH_CTL);

        // compare runs every cycle, counts on ticks
        equal       = (count_reg == constant_reg);
        // equality holds a whole tick period, so the clear lands on the
        // tick that leaves the constant value: period = constant + 1 ticks
        match_event = tick && equal;
    end

    // ----------------------------------------------------------------
    // control/status next-state
    // ----------------------------------------------------------------
    // the arm bit remembers a read that saw the
    // flag set; an accepted status write uses it
    // up, so a stale read cannot clear later
    always_comb begin
        match_irq_enable_next = match_irq_enable_reg;
        prescale_select_next  = prescale_select_reg;
        match_flag_next       = match_flag_reg;
        clear_armed_next      = clear_armed_reg;

        // a read that sees the flag at one arms the clear
        if (bus_req.rd && (bus_req.addr[2:1] == refresh_timer_pkg::ADDR_CTRL_STATUS[2:1])
            && match_flag_reg) begin
            clear_armed_next = 1'b1;
        end

        if (wr_status) begin
            match_irq_enable_next = wlow[refresh_timer_pkg::IRQ_EN_BIT];
            prescale_select_next  = refresh_timer_pkg::prescale_sel_t'(
                                        wlow[refresh_timer_pkg::SEL_HI:refresh_timer_pkg::SEL_LO]);
            // zero clears only if armed; one leaves the flag alone
            if (!wlow[refresh_timer_pkg::FLAG_BIT] && clear_armed_reg) begin
                match_flag_next = 1'b0;
            end
            // any accepted status write disarms
            clear_armed_next = 1'b0;
        end

        // hardware set wins over a clear in the same cycle
        if (match_event) begin
            match_flag_next = 1'b1;
        end

        // a flag already clear has nothing to arm
        if (!match_flag_next) begin
            clear_armed_next = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // counter, constant and refresh control next-state
    // ----------------------------------------------------------------
    // counter: clear on match, else step on a
    // tick; a software load overrides both
    always_comb begin
        count_next       = count_reg;
        constant_next    = constant_reg;
        refresh_ctl_next = refresh_ctl_reg;

        // clear beats step so the period is exact
        if (match_event) begin
            count_next = refresh_timer_pkg::RST_COUNT;
        end else if (tick) begin
            count_next = count_reg + 8'h01;
        end

        // software load beats a tick in the same cycle
        if (wr_count) begin
            count_next = wlow;
        end

        if (wr_constant) begin
            constant_next = wlow;
        end

        if (wr_refresh) begin
            refresh_ctl_next = wlow[refresh_timer_pkg::RF_EN_BIT:refresh_timer_pkg::RF_WAIT_LO];
        end

        // refresh only in refresh-enabled, non-self-refresh mode
        refresh_req_next = match_event
                           && refresh_ctl_reg[refresh_timer_pkg::RF_EN_BIT - refresh_timer_pkg::RF_WAIT_LO]
                           && !refresh_ctl_reg[refresh_timer_pkg::RF_SELF_BIT - refresh_timer_pkg::RF_WAIT_LO];
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // register image: upper byte always zero, reserved low bits zero
    // reads have no side effect here; the
    // flag arm lives in the status process
    always_comb begin
        // word image of the addressed register
        case (bus_req.addr[2:1])
            refresh_timer_pkg::ADDR_CTRL_STATUS[2:1]:
                reg_word = {refresh_timer_pkg::UPPER_READ, match_flag_reg, match_irq_enable_reg,
                            prescale_select_reg, 3'h0};
            refresh_timer_pkg::ADDR_COUNT[2:1]:
                reg_word = {refresh_timer_pkg::UPPER_READ, count_reg};
            refresh_timer_pkg::ADDR_CONSTANT[2:1]:
                reg_word = {refresh_timer_pkg::UPPER_READ, constant_reg};
            refresh_timer_pkg::ADDR_REFRESH_CTL[2:1]:
                reg_word = {refresh_timer_pkg::UPPER_READ, refresh_ctl_reg, 4'h0};
            default:
                reg_word = 16'h0000;
        endcase

        // only a read slot drives data; idle is zero
        rdata_next = 16'h0000;
        if (bus_req.rd) begin
            if (bus_req.word) begin
                rdata_next = reg_word;
            end else if (bus_req.addr[0]) begin
                rdata_next = {8'h00, reg_word[7:0]};                 // odd byte = low half
            end else begin
                rdata_next = {8'h00, reg_word[15:8]};                // even byte = upper, zero
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // only the power-on reset reaches this state; nothing else resets it
    // all state shares one clock and one reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // power-on values, constants only
            match_flag_reg       <= refresh_timer_pkg::RST_CTRL_STATUS[refresh_timer_pkg::FLAG_BIT];
            match_irq_enable_reg <= refresh_timer_pkg::RST_CTRL_STATUS[refresh_timer_pkg::IRQ_EN_BIT];
            prescale_select_reg  <= refresh_timer_pkg::SEL_OFF;
            count_reg            <= refresh_timer_pkg::RST_COUNT;
            constant_reg         <= refresh_timer_pkg::RST_CONSTANT;
            refresh_ctl_reg      <= refresh_timer_pkg::RST_REFRESH_CTL;
            clear_armed_reg      <= 1'b0;
            rdata_reg            <= 16'h0000;
            refresh_req_reg      <= 1'b0;
        end else begin
            // plain transfer, no logic here
            match_flag_reg       <= match_flag_next;
            match_irq_enable_reg <= match_irq_enable_next;
            prescale_select_reg  <= prescale_select_next;
            count_reg            <= count_next;
            constant_reg         <= constant_next;
            refresh_ctl_reg      <= refresh_ctl_next;
            clear_armed_reg      <= clear_armed_next;
            rdata_reg            <= rdata_next;
            refresh_req_reg      <= refresh_req_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // read data and the refresh pulse are
    // registered; the other outputs are decodes of registered state
    assign bus_rdata         = rdata_reg;

    // interrupt request is a level, not a pulse
    assign match_irq_request = match_flag_reg && match_irq_enable_reg;

    assign cas_first_refresh = refresh_req_reg;

    // self mode only counts while refresh is on
    assign self_refresh_mode = refresh_ctl_reg[refresh_timer_pkg::RF_EN_BIT - refresh_timer_pkg::RF_WAIT_LO]
                               && refresh_ctl_reg[refresh_timer_pkg::RF_SELF_BIT - refresh_timer_pkg::RF_WAIT_LO];

    // wait field passes straight through
    assign refresh_wait_sel  = refresh_ctl_reg[1:0];

endmodule : dram_refresh_interval_timer

//--- hw/refresh_prescaler.sv
// free-running system clock divider with a selectable tick tap
`timescale 1ns/1ps
module refresh_prescaler (
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    input  wire refresh_timer_pkg::prescale_sel_t sel,
    output logic                                 tick
);

    // ----------------------------------------------------------------
    // tap decode
    // ----------------------------------------------------------------
    // mask of low divider bits that must all be one for a tick
    function automatic logic [refresh_timer_pkg::DIV_W-1:0] tap_mask(
        input refresh_timer_pkg::prescale_sel_t s);
        case (s)
            refresh_timer_pkg::SEL_DIV2:    tap_mask = 12'h001;
            refresh_timer_pkg::SEL_DIV8:    tap_mask = 12'h007;
            refresh_timer_pkg::SEL_DIV32:   tap_mask = 12'h01F;
            refresh_timer_pkg::SEL_DIV128:  tap_mask = 12'h07F;
            refresh_timer_pkg::SEL_DIV512:  tap_mask = 12'h1FF;
            refresh_timer_pkg::SEL_DIV2048: tap_mask = 12'h7FF;
            refresh_timer_pkg::SEL_DIV4096: tap_mask = 12'hFFF;
            default:                        tap_mask = 12'h000;
        endcase
    endfunction : tap_mask

    logic [refresh_timer_pkg::DIV_W-1:0] div_reg;   // divider chain
    logic [refresh_timer_pkg::DIV_W-1:0] div_next;
    logic [refresh_timer_pkg::DIV_W-1:0] mask;      // selected tap
    logic                                tick_reg;  // registered tick
    logic                                tick_next;

    // ----------------------------------------------------------------
    // next-state
    // ----------------------------------------------------------------
    // divider runs free so a select change never restarts a period
    always_comb begin
        mask      = tap_mask(sel);
        div_next  = div_reg + 12'h001;
        tick_next = (sel != refresh_timer_pkg::SEL_OFF) && ((div_reg & mask) == mask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_reg  <= 12'h000;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : refresh_prescaler

//--- hw/refresh_timer_pkg.sv
// shared constants, field layout and bus carrier for the refresh interval timer
package refresh_timer_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses of 16-bit registers)
    // ----------------------------------------------------------------
    localparam logic [2:0]  ADDR_CTRL_STATUS = 3'h0;  // refresh_timer_ctrl_status
    localparam logic [2:0]  ADDR_COUNT       = 3'h2;  // refresh_interval_count
    localparam logic [2:0]  ADDR_CONSTANT    = 3'h4;  // refresh_match_constant
    localparam logic [2:0]  ADDR_REFRESH_CTL = 3'h6;  // refresh_control_reg

    // ----------------------------------------------------------------
    // write passwords carried in the upper byte of a word write
    // ----------------------------------------------------------------
    localparam logic [7:0]  PW_CTRL_STATUS   = 8'hA5;
    localparam logic [7:0]  PW_COUNT         = 8'h69;
    localparam logic [7:0]  PW_CONSTANT      = 8'h96;
    localparam logic [7:0]  PW_REFRESH_CTL   = 8'h5A;

    // ----------------------------------------------------------------
    // control/status field positions
    // ----------------------------------------------------------------
    localparam int          FLAG_BIT         = 7;     // match_flag
    localparam int          IRQ_EN_BIT       = 6;     // match_irq_enable
    localparam int          SEL_HI           = 5;     // prescale_select msb
    localparam int          SEL_LO           = 3;     // prescale_select lsb

    // ----------------------------------------------------------------
    // refresh control field positions
    // ----------------------------------------------------------------
    localparam int          RF_EN_BIT        = 7;     // refresh_enable
    localparam int          RF_SELF_BIT      = 6;     // self-refresh mode
    localparam int          RF_WAIT_HI       = 5;     // refresh wait states msb
    localparam int          RF_WAIT_LO       = 4;     // refresh wait states lsb

    // ----------------------------------------------------------------
    // power-on values and widths
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL_STATUS  = 8'h00;
    localparam logic [7:0]  RST_COUNT        = 8'h00;
    localparam logic [7:0]  RST_CONSTANT     = 8'hFF;
    localparam logic [3:0]  RST_REFRESH_CTL  = 4'h0;
    localparam logic [7:0]  UPPER_READ       = 8'h00;  // upper byte always reads zero
    localparam int          DIV_W            = 12;     // prescaler width, reaches /4096

    // ----------------------------------------------------------------
    // prescale_select codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_OFF, SEL_DIV2, SEL_DIV8, SEL_DIV32,
        SEL_DIV128, SEL_DIV512, SEL_DIV2048, SEL_DIV4096
    } prescale_sel_t;

    // ----------------------------------------------------------------
    // register bus request carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  addr;   // byte address
        logic [15:0] wdata;  // write data, upper byte = password on words
        logic        wr;     // write strobe, one cycle
        logic        rd;     // read strobe, one cycle
        logic        word;   // 1 = word access, 0 = byte access
    } bus_req_t;

endpackage : refresh_timer_pkg
